// [rtl/hpc_pkg.sv]
// package of constants and carriers for the homing parameter control block
//
// Overview of operation
// - count homing: first zero after travel distance
// - retry stops for dwell at each reversal
// - retry only for dog, count, cradle
// - shift from zero point, sign gives direction
// - nonzero shift uses homing or creep speed
// - shift only for dog, count, cradle, limit
// - creep torque limit only for stopper types
// - setting zero lets programs start always
// - setting one refuses start, minor error 121
// - home-return-only program always may start
// - jog and handwheel moves always accepted
// - flag set at power-up, reset, amp power unless absolute system
// - no blocking in test mode, real mode only
// - travel monitor invalid outside signed 32 bits
// - amp option one lifts zero-phase restriction
package hpc_pkg;
    localparam int CLK_HZ            = 25_000_000;
    localparam int DWELL_UNIT_US     = 1000;
    localparam int CYC_PER_MS        = (CLK_HZ / 1_000_000) * DWELL_UNIT_US;
    localparam int DWELL_MAX_MS      = 5000;
    localparam logic [7:0] MINOR_ERR_HOMING = 8'h79;
    localparam logic [9:0] TORQUE_RESET     = 10'h12c;
    localparam logic [9:0] TORQUE_FULL      = 10'h3e8;

    // homing method codes
    localparam logic [3:0] M_DOG1 = 4'h0;
    localparam logic [3:0] M_CNT1 = 4'h1;
    localparam logic [3:0] M_DS1  = 4'h2;
    localparam logic [3:0] M_DS2  = 4'h3;
    localparam logic [3:0] M_DOG2 = 4'h4;
    localparam logic [3:0] M_CNT2 = 4'h5;
    localparam logic [3:0] M_CNT3 = 4'h6;
    localparam logic [3:0] M_CRAD = 4'h7;
    localparam logic [3:0] M_STP1 = 4'h8;
    localparam logic [3:0] M_STP2 = 4'h9;
    localparam logic [3:0] M_LIM  = 4'ha;

    typedef enum logic [1:0] {SPD_STOP, SPD_HOMING, SPD_CREEP} hpc_speed_e;

    // homing setup, held stable while a homing run is active
    typedef struct packed {
        logic        dirUp;
        logic [3:0]  method;
        logic [31:0] travelAfterDog;
        logic        retryEn;
        logic [12:0] dwellMs;
        logic [31:0] shiftAmt;
        logic        shiftAtCreep;
        logic [9:0]  creepTorque;
        logic        blockIncomplete;
    } hpc_cfg_s;

    // motion command toward the axis
    typedef struct packed {
        hpc_speed_e  speed;
        logic        dirUp;
        logic [9:0]  torqueLimit;
    } hpc_move_s;

    // program start request
    typedef struct packed {
        logic        req;
        logic        homeOnly;
        logic        jogOrHandwheel;
        logic        virtualAxis;
        logic        realMode;
    } hpc_start_s;

    // method class decode, used by several places
    function automatic logic isCount(input logic [3:0] m);
        return (m == M_CNT1) || (m == M_CNT2) || (m == M_CNT3);
    endfunction
    function automatic logic isDog(input logic [3:0] m);
        return (m == M_DOG1) || (m == M_DOG2);
    endfunction
    function automatic logic isStopper(input logic [3:0] m);
        return (m == M_STP1) || (m == M_STP2);
    endfunction
endpackage

// [rtl/hpc_ms_timer.sv]
// dwell timer counting whole milliseconds
`timescale 1ns/1ps
module hpc_ms_timer
    import hpc_pkg::*;
#(
    parameter int CYC_MS = CYC_PER_MS
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    // control
    input  wire logic        start,
    input  wire logic [12:0] ms,
    // status
    output logic             busy
);
    // refuse tick counts that the 16-bit divider cannot hold
    if (CYC_MS < 1 || CYC_MS > 65536) begin : g_bad_cyc
        $error("CYC_MS must lie between 1 and 65536");
    end

    logic [15:0] tickCnt_ff;
    logic [12:0] msLeft_ff;

    // millisecond tick divider and remaining count
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            tickCnt_ff <= 16'h0000;
            msLeft_ff  <= 13'h0000;
        end else if (start) begin
            tickCnt_ff <= 16'h0000;
            msLeft_ff  <= ms;
        end else if (msLeft_ff != 13'h0000) begin
            if (tickCnt_ff == 16'(CYC_MS - 1)) begin
                tickCnt_ff <= 16'h0000;
                msLeft_ff  <= msLeft_ff - 13'h0001;
            end else begin
                tickCnt_ff <= tickCnt_ff + 16'h0001;
            end
        end
    end

    assign busy = start || (msLeft_ff != 13'h0000);
endmodule // hpc_ms_timer

// [rtl/hpc_start_gate.sv]
// program start gating against pending homing
`timescale 1ns/1ps
module hpc_start_gate
    import hpc_pkg::*;
(
    // request and state
    input  wire hpc_start_s  startReq,
    input  wire logic        blockIncomplete,
    input  wire logic        homingRequired,
    // verdict
    output logic             accept,
    output logic             refuse
);
    logic blocked;

    // refuse only plain programs on a real axis with homing pending
    always_comb begin
        blocked = blockIncomplete && homingRequired
                  && !startReq.homeOnly
                  && !startReq.jogOrHandwheel
                  && startReq.realMode && !startReq.virtualAxis;
        accept  = startReq.req && !blocked;
        refuse  = startReq.req && blocked;
    end
endmodule // hpc_start_gate

// [rtl/hpc_homing_ctrl.sv]
// per-axis home return sequencer with shift, retry and start gating
`timescale 1ns/1ps
module hpc_homing_ctrl
    import hpc_pkg::*;
#(
    parameter int CYC_MS = CYC_PER_MS
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    // configuration
    input  wire hpc_cfg_s    cfg,
    input  wire logic        absSystem,
    input  wire logic        noZeroPassOpt,
    // commands
    input  wire logic        homeStart,
    input  wire hpc_start_s  startReq,
    input  wire logic        ampPowerUp,
    // axis feedback
    input  wire logic        dogIn,
    input  wire logic        zeroPulse,
    input  wire logic        limitIn,
    input  wire logic        stopperHit,
    input  wire logic        moveDone,
    input  wire logic [31:0] travelPulses,
    // outputs
    output hpc_move_s        moveCmd,
    output logic [31:0]      shiftTarget,
    output logic             shiftActive,
    output logic             homingRequired,
    output logic             homeDone,
    output logic             startAccept,
    output logic             startRefused,
    output logic [7:0]       minorError,
    output logic [31:0]      dogTravelMon,
    output logic             dogTravelValid
);
    typedef enum logic [3:0] {
        ST_IDLE, ST_SEEK, ST_DWELL, ST_REVERSE, ST_CREEP,
        ST_COUNT, ST_ZERO, ST_SHIFT, ST_DONE
    } hpc_state_e;

    hpc_state_e  state_ff;
    hpc_move_s   moveCmd_ff;
    logic [31:0] shiftTarget_ff;
    logic        shiftActive_ff;
    logic        homingRequired_ff;
    logic        homeDone_ff;
    logic        startAccept_ff;
    logic        startRefused_ff;
    logic [7:0]  minorError_ff;
    logic [31:0] dogTravelMon_ff;
    logic        dogTravelValid_ff;
    logic        zeroSeen_ff;
    logic        dirUp_ff;
    logic        dogSeen_ff;
    logic        secondDwell_ff;
    logic        dwellStart;
    logic        dwellBusy;
    logic        gateAccept;
    logic        gateRefuse;
    logic        retryOk;
    logic        shiftOk;
    logic        needZeroPass;
    logic [32:0] monSum;

    // the dwell divider holds at most 16 bits of cycles per millisecond
    if (CYC_MS < 1 || CYC_MS > 65536) begin : g_bad_cyc_ms
        $error("CYC_MS must lie between 1 and 65536");
    end

    assign retryOk = cfg.retryEn
                     && (isDog(cfg.method) || isCount(cfg.method)
                         || (cfg.method == M_CRAD));
    assign shiftOk = (cfg.shiftAmt != 32'h0000_0000)
                     && (isDog(cfg.method) || isCount(cfg.method)
                         || (cfg.method == M_CRAD) || (cfg.method == M_LIM));
    assign needZeroPass = !noZeroPassOpt && !zeroSeen_ff;
    // dwell at the limit, and again once the dog has been passed backing off
    assign dwellStart = ((state_ff == ST_SEEK) && limitIn && retryOk)
                        || ((state_ff == ST_REVERSE) && dogSeen_ff && !dogIn);
    assign monSum = {travelPulses[31], travelPulses} + {cfg.shiftAmt[31], cfg.shiftAmt};

    hpc_ms_timer #(
        .CYC_MS (CYC_MS)
    ) u_dwell (
        .core_clk (core_clk),
        .reset    (reset),
        .start    (dwellStart),
        .ms       (cfg.dwellMs),
        .busy     (dwellBusy)
    );

    hpc_start_gate u_gate (
        .startReq        (startReq),
        .blockIncomplete (cfg.blockIncomplete),
        .homingRequired  (homingRequired_ff),
        .accept          (gateAccept),
        .refuse          (gateRefuse)
    );

    // zero phase passed since reset
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            zeroSeen_ff <= 1'b0;
        end else if (zeroPulse) begin
            zeroSeen_ff <= 1'b1;
        end
    end

    // dog passed while backing off the limit
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            dogSeen_ff <= 1'b0;
        end else if (state_ff != ST_REVERSE) begin
            dogSeen_ff <= 1'b0;
        end else if (dogIn) begin
            dogSeen_ff <= 1'b1;
        end
    end

    // homing sequence
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_ff       <= ST_IDLE;
            dirUp_ff       <= 1'b0;
            secondDwell_ff <= 1'b0;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (homeStart) begin
                        dirUp_ff       <= cfg.dirUp;
                        secondDwell_ff <= 1'b0;
                        if (cfg.method == M_DS1 || cfg.method == M_DS2) begin
                            state_ff <= needZeroPass ? ST_IDLE : ST_DONE;
                        end else begin
                            state_ff <= ST_SEEK;
                        end
                    end
                end
                ST_SEEK: begin
                    if (dwellStart) begin
                        state_ff <= ST_DWELL;
                    end else if (isStopper(cfg.method) && stopperHit) begin
                        state_ff <= ST_DONE;
                    end else if (dogIn || (cfg.method == M_LIM && limitIn)) begin
                        state_ff <= isCount(cfg.method) ? ST_COUNT : ST_CREEP;
                    end
                end
                ST_DWELL: begin
                    if (!dwellBusy) begin
                        dirUp_ff       <= !dirUp_ff;
                        secondDwell_ff <= !secondDwell_ff;
                        state_ff       <= secondDwell_ff ? ST_SEEK : ST_REVERSE;
                    end
                end
                ST_REVERSE: begin
                    if (dwellStart) begin
                        state_ff <= ST_DWELL;
                    end
                end
                ST_CREEP: begin
                    if (isStopper(cfg.method) ? stopperHit : !dogIn) begin
                        state_ff <= isStopper(cfg.method) ? ST_DONE : ST_ZERO;
                    end
                end
                ST_COUNT: begin
                    if (travelPulses >= cfg.travelAfterDog) begin
                        state_ff <= ST_ZERO;
                    end
                end
                ST_ZERO: begin
                    if (zeroPulse && !needZeroPass) begin
                        state_ff <= shiftOk ? ST_SHIFT : ST_DONE;
                    end
                end
                ST_SHIFT: begin
                    if (moveDone) begin
                        state_ff <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state_ff <= ST_IDLE;
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // motion command toward the amplifier
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            moveCmd_ff <= '{speed: SPD_STOP, dirUp: 1'b0, torqueLimit: TORQUE_FULL};
        end else begin
            moveCmd_ff.dirUp       <= dirUp_ff;
            moveCmd_ff.torqueLimit <= TORQUE_FULL;
            unique case (state_ff)
                ST_SEEK, ST_REVERSE, ST_COUNT: moveCmd_ff.speed <= SPD_HOMING;
                ST_CREEP, ST_ZERO: begin
                    moveCmd_ff.speed <= SPD_CREEP;
                    if (isStopper(cfg.method)) begin
                        moveCmd_ff.torqueLimit <= cfg.creepTorque;
                    end
                end
                ST_SHIFT: begin
                    moveCmd_ff.speed <= cfg.shiftAtCreep ? SPD_CREEP : SPD_HOMING;
                    moveCmd_ff.dirUp <= !cfg.shiftAmt[31];
                end
                default: moveCmd_ff.speed <= SPD_STOP;
            endcase
        end
    end

    // shift target and post-dog travel monitor
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            shiftTarget_ff    <= 32'h0000_0000;
            shiftActive_ff    <= 1'b0;
            dogTravelMon_ff   <= 32'h0000_0000;
            dogTravelValid_ff <= 1'b0;
        end else begin
            shiftActive_ff <= (state_ff == ST_SHIFT);
            if (state_ff == ST_ZERO && zeroPulse && shiftOk) begin
                shiftTarget_ff    <= cfg.shiftAmt;
                dogTravelMon_ff   <= monSum[31:0];
                dogTravelValid_ff <= (monSum[32] == monSum[31]);
            end else if (state_ff == ST_ZERO && zeroPulse) begin
                dogTravelMon_ff   <= travelPulses;
                dogTravelValid_ff <= 1'b1;
            end
        end
    end

    // homing-required flag, power-up set wins over completion
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            homingRequired_ff <= 1'b1;
            homeDone_ff       <= 1'b0;
        end else begin
            homeDone_ff <= (state_ff == ST_DONE);
            if (ampPowerUp && !absSystem) begin
                homingRequired_ff <= 1'b1;
            end else if (state_ff == ST_DONE) begin
                homingRequired_ff <= 1'b0;
            end
        end
    end

    // start verdict and minor error
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            startAccept_ff  <= 1'b0;
            startRefused_ff <= 1'b0;
            minorError_ff   <= 8'h00;
        end else begin
            startAccept_ff  <= gateAccept;
            startRefused_ff <= gateRefuse;
            if (gateRefuse) begin
                minorError_ff <= MINOR_ERR_HOMING;
            end else if (gateAccept) begin
                minorError_ff <= 8'h00;
            end
        end
    end

    assign moveCmd        = moveCmd_ff;
    assign shiftTarget    = shiftTarget_ff;
    assign shiftActive    = shiftActive_ff;
    assign homingRequired = homingRequired_ff;
    assign homeDone       = homeDone_ff;
    assign startAccept    = startAccept_ff;
    assign startRefused   = startRefused_ff;
    assign minorError     = minorError_ff;
    assign dogTravelMon   = dogTravelMon_ff;
    assign dogTravelValid = dogTravelValid_ff;
endmodule // hpc_homing_ctrl

// [tb/hpc_homing_assertions.sv]
// port assertions for the homing sequencer
`timescale 1ns/1ps
module hpc_homing_assertions
    import hpc_pkg::*;
(
    // clock and reset
    input wire logic        core_clk,
    input wire logic        reset,
    // inputs
    input wire hpc_cfg_s    cfg,
    input wire logic        absSystem,
    input wire hpc_start_s  startReq,
    input wire logic        ampPowerUp,
    // outputs
    input wire hpc_move_s   moveCmd,
    input wire logic        shiftActive,
    input wire logic        homingRequired,
    input wire logic        homeDone,
    input wire logic        startAccept,
    input wire logic        startRefused,
    input wire logic [7:0]  minorError
);
    logic blk;
    // refusal condition of a program start
    assign blk = cfg.blockIncomplete && homingRequired && !startReq.homeOnly
        && !startReq.jogOrHandwheel && startReq.realMode && !startReq.virtualAxis;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    gate_refuse_a: assert property (startReq.req && blk |=> startRefused)
        else $error("start not refused");
    gate_accept_a: assert property (startReq.req && !blk |=> startAccept)
        else $error("start not accepted");
    err_code_a: assert property (startRefused |-> minorError == MINOR_ERR_HOMING)
        else $error("wrong minor error code");
    torque_stop_a: assert property (moveCmd.speed == SPD_CREEP
        && moveCmd.torqueLimit != TORQUE_FULL |-> isStopper(cfg.method))
        else $error("creep torque limit outside stopper homing");
    shift_method_a: assert property (shiftActive |-> cfg.shiftAmt != 32'h0
        && (isDog(cfg.method) || isCount(cfg.method) || cfg.method == M_CRAD
        || cfg.method == M_LIM))
        else $error("shift move for wrong method");
    shift_move_a: assert property ($rose(shiftActive) |=> moveCmd.dirUp == !cfg.shiftAmt[31]
        && moveCmd.speed == (cfg.shiftAtCreep ? SPD_CREEP : SPD_HOMING))
        else $error("shift direction or speed wrong");
    done_clear_a: assert property (homeDone && !$past(ampPowerUp) |-> !homingRequired)
        else $error("flag kept after homing");
    amp_flag_a: assert property (ampPowerUp && !absSystem |=> homingRequired)
        else $error("flag not set at amplifier power up");
endmodule // hpc_homing_assertions

bind hpc_homing_ctrl hpc_homing_assertions chk_u (.core_clk, .reset, .cfg, .absSystem,
    .startReq, .ampPowerUp, .moveCmd, .shiftActive, .homingRequired, .homeDone,
    .startAccept, .startRefused, .minorError);

// [tb/hpc_axis_model.sv]
// axis model: travel, dog, zero marks, stopper and shift completion
`timescale 1ns/1ps
module hpc_axis_model
    import hpc_pkg::*;
(
    // clock, reset and restart
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        clr,
    // commands
    input  wire hpc_move_s   moveCmd,
    input  wire logic        shiftActive,
    input  wire logic [31:0] travel,
    // feedback
    output logic             dogIn,
    output logic             limitIn,
    output logic             zeroPulse,
    output logic             stopperHit,
    output logic             moveDone,
    output logic [31:0]      travelPulses,
    output logic [3:0]       zerosAfter
);
    logic signed [31:0] pos;
    logic [3:0]  shCnt;
    logic        moving;
    // switches and marks derived from position
    assign moving = moveCmd.speed != SPD_STOP;
    assign dogIn = pos >= 32'sd10 && pos < 32'sd30;
    assign limitIn = pos <= -32'sd5;
    assign travelPulses = (pos >= 32'sd10) ? 32'(pos - 32'sd10) : 32'h0;
    assign zeroPulse = moving && pos[3:0] == 4'h7;
    assign stopperHit = moveCmd.speed == SPD_CREEP && pos >= 32'sd20;
    assign moveDone = shiftActive && shCnt == 4'h5;
    // position, shift timer, zero marks past the travel
    always_ff @(posedge core_clk) begin
        if (reset || clr) begin
            pos <= 32'h0;
            shCnt <= 4'h0;
            zerosAfter <= 4'h0;
        end else begin
            pos <= !moving ? pos : moveCmd.dirUp ? pos + 32'sd1 : pos - 32'sd1;
            shCnt <= shiftActive ? shCnt + 4'h1 : 4'h0;
            if (zeroPulse && !shiftActive && travelPulses >= travel)
                zerosAfter <= zerosAfter + 4'h1;
        end
    end
endmodule // hpc_axis_model

// [tb/tb_hpc_homing_ctrl.sv]
// self-checking bench for the homing sequencer
`timescale 1ns/1ps
module tb_hpc_homing_ctrl;
    import hpc_pkg::*;
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    hpc_cfg_s    cfg = '0;
    logic        absSystem = 1'b0;
    logic        noZeroPassOpt = 1'b0;
    logic        homeStart = 1'b0;
    hpc_start_s  startReq = '0;
    logic        ampPowerUp = 1'b0;
    logic        clr = 1'b1;
    logic        dogIn, zeroPulse, stopperHit, moveDone, limitIn;
    logic [31:0] travelPulses, shiftTarget, dogTravelMon;
    logic [3:0]  zerosAfter;
    hpc_move_s   moveCmd;
    logic        shiftActive, homingRequired, homeDone;
    logic        startAccept, startRefused, dogTravelValid;
    logic [7:0]  minorError;
    logic        expReq = 1'b1;
    int          miscompares = 0;
    int          num_checks = 0;
    int          cyc = 0;
    localparam int TB_CYC_MS = 2; // short millisecond for the bench
    // 25 MHz clock
    always #20 core_clk = ~core_clk;
    // hang guard
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            final_report();
        end
    end
    hpc_homing_ctrl #(.CYC_MS(TB_CYC_MS)) dut_u (.core_clk, .reset, .cfg, .absSystem,
        .noZeroPassOpt, .homeStart, .startReq, .ampPowerUp, .dogIn, .zeroPulse,
        .limitIn, .stopperHit, .moveDone, .travelPulses, .moveCmd, .shiftTarget,
        .shiftActive, .homingRequired, .homeDone, .startAccept, .startRefused,
        .minorError, .dogTravelMon, .dogTravelValid);
    hpc_axis_model ax_u (.core_clk, .reset, .clr, .moveCmd, .shiftActive,
        .travel(cfg.travelAfterDog), .dogIn, .limitIn, .zeroPulse, .stopperHit, .moveDone,
        .travelPulses, .zerosAfter);
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // one random program start, verdict worked out here
    task automatic rgate();
        hpc_start_s s;
        logic blk, refs;
        s = hpc_start_s'(5'($urandom));
        s.req = 1'b1;
        blk = 1'($urandom);
        refs = blk & expReq & ~s.homeOnly & ~s.jogOrHandwheel & s.realMode & ~s.virtualAxis;
        @(posedge core_clk);
        cfg.blockIncomplete <= blk;
        startReq <= s;
        @(posedge core_clk);
        startReq.req <= 1'b0;
        #1;
        chk(startRefused, refs);
        chk(startAccept, !refs);
        if (refs)
            chk(minorError, MINOR_ERR_HOMING);
    endtask
    // one homing run with shift, speed choice and outcome checks
    task automatic home(input logic [3:0] m, input logic [31:0] sh, input logic crp,
                        input logic expDone, input int lim);
        hpc_cfg_s c;
        logic done, sawSh, sawTq, moved, inRange;
        logic [31:0] atZero;
        logic [2:0] shExp;
        int t, stops, expStops;
        longint monExp;
        c = cfg;
        c.method = m;
        c.shiftAmt = sh;
        c.shiftAtCreep = crp;
        t = $urandom_range(23, 1);
        if (t >= 13)
            t++; // keep the travel end off the zero mark at 13
        c.travelAfterDog = 32'(t);
        c.creepTorque = $urandom_range(999, 1);
        done = 1'b0;
        sawSh = 1'b0;
        sawTq = 1'b0;
        moved = 1'b0;
        stops = 0;
        shExp = {!sh[31], crp ? SPD_CREEP : SPD_HOMING};
        @(posedge core_clk);
        cfg <= c;
        clr <= 1'b1;
        @(posedge core_clk);
        clr <= 1'b0;
        homeStart <= 1'b1;
        @(posedge core_clk);
        homeStart <= 1'b0;
        for (int n = 0; n < lim && !done; n++) begin
            @(posedge core_clk);
            #1;
            done = homeDone === 1'b1;
            sawSh |= shiftActive === 1'b1;
            sawTq |= moveCmd.speed == SPD_CREEP && moveCmd.torqueLimit === c.creepTorque;
            moved |= moveCmd.speed != SPD_STOP;
            if (moved && homeDone !== 1'b1 && moveCmd.speed == SPD_STOP)
                stops++;
            if (shiftActive === 1'b1)
                chk({moveCmd.dirUp, moveCmd.speed}, shExp);
        end
        chk(done, expDone);
        expStops = 0;
        if (c.retryEn && !c.dirUp && (isDog(m) || isCount(m) || m == M_CRAD))
            expStops = 2 * (c.dwellMs * TB_CYC_MS + 1);
        chk(stops, expStops);
        if (expDone) begin
            expReq = 1'b0;
            chk(homingRequired, 1'b0);
            chk(sawSh, sh != 0 && (isDog(m) || isCount(m) || m == M_LIM));
            chk(sawTq, isStopper(m));
            if (sawSh)
                chk(shiftTarget, sh);
            if (isCount(m)) begin
                chk(zerosAfter, 4'h1);
                atZero = (t < 13) ? 32'd13 : 32'd29;
                monExp = longint'($signed(atZero)) + longint'($signed(sh));
                inRange = (monExp >= -64'sd2147483648) && (monExp <= 64'sd2147483647);
                chk(dogTravelValid, inRange);
                if (inRange)
                    chk(dogTravelMon, atZero + sh);
            end
        end
    endtask
    // main sequence
    initial begin
        void'($urandom(41));
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        cfg.dirUp <= 1'b1;
        @(posedge core_clk);
        #1;
        chk(homingRequired, 1'b1);
        chk(moveCmd.torqueLimit, TORQUE_FULL);
        repeat (40) rgate();
        home(M_DS1, 32'h0, 1'b0, 1'b0, 20);
        @(posedge core_clk);
        noZeroPassOpt <= 1'b1;
        home(M_DS2, 32'h0, 1'b0, 1'b1, 20);
        repeat (20) rgate();
        @(posedge core_clk);
        absSystem <= 1'b1;
        ampPowerUp <= 1'b1;
        @(posedge core_clk);
        ampPowerUp <= 1'b0;
        @(posedge core_clk);
        #1;
        chk(homingRequired, 1'b0);
        @(posedge core_clk);
        absSystem <= 1'b0;
        ampPowerUp <= 1'b1;
        @(posedge core_clk);
        ampPowerUp <= 1'b0;
        noZeroPassOpt <= 1'b0;
        @(posedge core_clk);
        #1;
        chk(homingRequired, 1'b1);
        expReq = 1'b1;
        repeat (10) rgate();
        home(M_CNT1, -32'sd5, 1'b1, 1'b1, 600);
        home(M_DOG1, 32'd7, 1'b0, 1'b1, 600);
        home(M_LIM, 32'd9, 1'b1, 1'b1, 600);
        home(M_STP2, 32'd4, 1'b0, 1'b1, 600);
        home(M_DS1, 32'd4, 1'b0, 1'b1, 20);
        home(M_CNT3, 32'h7fff_fffa, 1'b0, 1'b1, 600);
        // approach away from the dog so the limit forces a retry
        @(posedge core_clk);
        cfg.retryEn <= 1'b1;
        cfg.dirUp <= 1'b0;
        cfg.dwellMs <= 13'($urandom_range(4, 1));
        @(posedge core_clk);
        home(M_DOG2, 32'h0, 1'b0, 1'b1, 600);
        home(M_LIM, 32'h0, 1'b0, 1'b1, 600);
        repeat (10) rgate();
        final_report();
    end
endmodule // tb_hpc_homing_ctrl
